/* File: rtl/scg_delay_cnt.sv */
// Down counter that pulses done after a loaded number of cycles.
// Assumes a one-cycle start pulse; a new start reloads the count.
module scg_delay_cnt #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] loadVal,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_q;
  logic             busy_q;

  // ========================================================================
  // Countdown; done pulses in the cycle the count reaches zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done   <= 1'b0;
    end else if (start) begin
      cnt_q  <= (loadVal == '0) ? CNT_W'(1) : loadVal;
      busy_q <= 1'b1;
      done   <= 1'b0;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - CNT_W'(1);
      busy_q <= (cnt_q != CNT_W'(1));
      done   <= (cnt_q == CNT_W'(1));
    end else begin
      done <= 1'b0;
    end
  end

endmodule : scg_delay_cnt

/* File: rtl/scg_sleep_ctrl.sv */
// Sleep-mode controller: gates clock domains, filters wake-ups, times wake.
// Assumes sleepExec is a one-cycle pulse from the core on a sleep instruction
// and resetReq is the merged external, watchdog and brown-out reset request.
`include "scg_regs.svh"
module scg_sleep_ctrl #(
  parameter int unsigned CNT_W  = 16,
  parameter logic [15:0] TOUT0  = 16'h0006,
  parameter logic [15:0] TOUT1  = 16'h0400,
  parameter logic [15:0] TOUT2  = 16'h1000,
  parameter logic [15:0] TOUT3  = 16'h4000
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       sleepEnableBit,
  input  wire logic       sleepExec,
  input  wire logic [2:0] sleepModeSelect,
  input  wire logic       extCrystalSel,
  input  wire logic [1:0] clockSelectFuses,
  input  wire logic       debugEnableFuse,
  input  wire logic       jtagEnableFuse,
  input  wire logic       jtagDisableBit,
  input  wire logic       brownoutEnableFuse,
  input  wire logic       wdtEnable,
  input  wire logic       convEnable,
  input  wire logic       convBegin,
  input  wire logic       compDisableBit,
  input  wire logic       compBandgapSel,
  input  wire logic       timer0AsyncClockBit,
  input  wire logic       t0OvfIrqEn,
  input  wire logic       t0CmpIrqEn,
  input  wire logic       globalIrqEnable,
  input  wire logic       t0Ovf,
  input  wire logic       t0Cmp,
  input  wire logic       anyIrq,
  input  wire logic       compIrq,
  input  wire logic       convDoneIrq,
  input  wire logic       twiAddrMatch,
  input  wire logic       storeReadyIrq,
  input  wire logic [3:0] upperExtLevelIrq,
  input  wire logic [3:0] lowerExtIrq,
  input  wire logic       resetReq,
  input  wire logic       tapShifting,
  input  wire logic       tdoData,
  output logic            cpuClkEn_q,
  output logic            flashClkEn_q,
  output logic            ioClkEn_q,
  output logic            convClkEn_q,
  output logic            asyClkEn_q,
  output logic            mainOscEn_q,
  output logic            timerOscEn_q,
  output logic            sleeping_q,
  output logic            coreHalted_q,
  output logic            wakeDone_q,
  output logic            resetVector_q,
  output logic            convStart_q,
  output logic            convExtended_q,
  output logic            convPowered_q,
  output logic            compPowered_q,
  output logic            vrefEn_q,
  output logic            brownout_enable_fuse_q,
  output logic            wdtRun_q,
  output logic            inputBufEn_q,
  output logic            extIrqBufEn_q,
  output logic            timer0Undefined_q,
  output logic            jtagActive_q,
  output logic            tdoOut_q,
  output logic            tdoOe_q
);

  // ========================================================================
  // Mode decoding helpers
  function automatic logic isDeep(input scg_pkg::scg_mode_t m);
    isDeep = (m == `SCG_MODE_PWRDOWN) || (m == `SCG_MODE_PWRSAVE) ||
             (m == `SCG_MODE_STANDBY) || (m == `SCG_MODE_EXTSTBY);
  endfunction : isDeep

  function automatic logic isSaveLike(input scg_pkg::scg_mode_t m);
    isSaveLike = (m == `SCG_MODE_PWRSAVE) || (m == `SCG_MODE_EXTSTBY);
  endfunction : isSaveLike

  function automatic logic modeOk(input scg_pkg::scg_mode_t m, input logic xtal);
    modeOk = (m != `SCG_MODE_RSVD4) && (m != `SCG_MODE_RSVD5) &&
             (xtal || (m != `SCG_MODE_STANDBY && m != `SCG_MODE_EXTSTBY));
  endfunction : modeOk

  scg_pkg::scg_state_e state_q;
  scg_pkg::scg_mode_t  mode_q;
  logic                enter;
  logic                wake;
  logic                t0AsyncWake;
  logic                jtagOn;
  logic                dbgHold;
  logic                dlyStart;
  logic [CNT_W-1:0]    dlyLoad;
  logic                dlyDone;
  logic                haltStart;
  logic                haltDone;
  logic                convEnPrev_q;
  logic [15:0]         tout;

  // ========================================================================
  // Request decode
  assign enter = sleepExec & sleepEnableBit & modeOk(sleepModeSelect, extCrystalSel);
  assign t0AsyncWake = globalIrqEnable & ((t0Ovf & t0OvfIrqEn) | (t0Cmp & t0CmpIrqEn));
  assign jtagOn  = jtagEnableFuse & ~jtagDisableBit;
  assign dbgHold = debugEnableFuse & jtagOn;

  // Start-up time-out chosen by the clock select fuses
  always_comb begin
    unique case (clockSelectFuses)
      2'h0: tout = TOUT0;
      2'h1: tout = TOUT1;
      2'h2: tout = TOUT2;
      2'h3: tout = TOUT3;
    endcase
  end

  // ========================================================================
  // Wake-up source filter and delay timers
  scg_wake_match u_wake (
    .mode                (state_q == scg_pkg::ST_SLEEP),
    .sleepMode           (mode_q),
    .anyIrq              (anyIrq),
    .compIrq             (compIrq),
    .compDisableBit      (compDisableBit),
    .convDoneIrq         (convDoneIrq),
    .twiAddrMatch        (twiAddrMatch),
    .timer0Irq           (t0AsyncWake),
    .storeReadyIrq       (storeReadyIrq),
    .upperExtLevelIrq    (upperExtLevelIrq),
    .lowerExtIrq         (lowerExtIrq),
    .timer0AsyncClockBit (timer0AsyncClockBit),
    .t0AsyncWake         (t0AsyncWake),
    .wake                (wake)
  );

  // Clock restart delay: fuse time-out when oscillator stopped, six otherwise
  always_comb begin
    dlyLoad = '0;
    if (mode_q == `SCG_MODE_STANDBY || mode_q == `SCG_MODE_EXTSTBY || dbgHold) begin
      dlyLoad = CNT_W'(`SCG_STANDBY_WAKE_CYC);
    end else begin
      dlyLoad = CNT_W'(tout);
    end
  end

  assign dlyStart  = (state_q == scg_pkg::ST_SLEEP) & wake & ~resetReq & isDeep(mode_q);
  assign haltStart = ((state_q == scg_pkg::ST_SLEEP) & wake & ~resetReq & ~isDeep(mode_q)) |
                     ((state_q == scg_pkg::ST_CLKWAIT) & dlyDone & ~resetReq);

  scg_delay_cnt #(.CNT_W(CNT_W)) u_clkdly (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (dlyStart),
    .loadVal (dlyLoad),
    .done    (dlyDone)
  );

  scg_delay_cnt #(.CNT_W(CNT_W)) u_haltdly (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (haltStart),
    .loadVal (CNT_W'(`SCG_HALT_EXTRA_CYC)),
    .done    (haltDone)
  );

  // ========================================================================
  // Sleep sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= scg_pkg::ST_RUN;
      mode_q  <= `SCG_RST_MODE;
    end else begin
      unique case (state_q)
        scg_pkg::ST_RUN: begin
          if (enter) begin
            state_q <= scg_pkg::ST_SLEEP;
            mode_q  <= sleepModeSelect;
          end
        end
        scg_pkg::ST_SLEEP: begin
          if (resetReq) begin
            state_q <= scg_pkg::ST_RUN;
          end else if (dlyStart) begin
            state_q <= scg_pkg::ST_CLKWAIT;
          end else if (haltStart) begin
            state_q <= scg_pkg::ST_HALT;
          end
        end
        scg_pkg::ST_CLKWAIT: begin
          if (resetReq) begin
            state_q <= scg_pkg::ST_RUN;
          end else if (dlyDone) begin
            state_q <= scg_pkg::ST_HALT;
          end
        end
        scg_pkg::ST_HALT: begin
          if (haltDone) begin
            state_q <= scg_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  // Wake and reset-vector pulses to the core
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wakeDone_q    <= 1'b0;
      resetVector_q <= 1'b0;
    end else begin
      wakeDone_q    <= (state_q == scg_pkg::ST_HALT) & haltDone;
      resetVector_q <= resetReq & ((state_q == scg_pkg::ST_SLEEP) |
                                   (state_q == scg_pkg::ST_CLKWAIT));
    end
  end

  // ========================================================================
  // Clock domain gating per state and mode
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpuClkEn_q   <= `SCG_RST_CLK_EN;
      flashClkEn_q <= `SCG_RST_CLK_EN;
      ioClkEn_q    <= `SCG_RST_CLK_EN;
      convClkEn_q  <= `SCG_RST_CLK_EN;
      asyClkEn_q   <= `SCG_RST_CLK_EN;
      mainOscEn_q  <= `SCG_RST_CLK_EN;
      timerOscEn_q <= 1'b0;
      sleeping_q   <= 1'b0;
      coreHalted_q <= 1'b0;
    end else begin
      cpuClkEn_q   <= (state_q == scg_pkg::ST_RUN);
      flashClkEn_q <= (state_q == scg_pkg::ST_RUN);
      timerOscEn_q <= timer0AsyncClockBit;
      sleeping_q   <= (state_q == scg_pkg::ST_SLEEP);
      coreHalted_q <= (state_q != scg_pkg::ST_RUN);
      if (state_q == scg_pkg::ST_RUN || state_q == scg_pkg::ST_HALT) begin
        ioClkEn_q   <= 1'b1;
        convClkEn_q <= 1'b1;
        asyClkEn_q  <= 1'b1;
        mainOscEn_q <= 1'b1;
      end else if (mode_q == `SCG_MODE_IDLE) begin
        ioClkEn_q   <= 1'b1;
        convClkEn_q <= 1'b1;
        asyClkEn_q  <= 1'b1;
        mainOscEn_q <= 1'b1;
      end else if (mode_q == `SCG_MODE_NOISE) begin
        ioClkEn_q   <= 1'b0;
        convClkEn_q <= 1'b1;
        asyClkEn_q  <= 1'b1;
        mainOscEn_q <= 1'b1;
      end else begin
        ioClkEn_q   <= 1'b0;
        convClkEn_q <= 1'b0;
        asyClkEn_q  <= isSaveLike(mode_q) & timer0AsyncClockBit;
        mainOscEn_q <= dbgHold | (state_q == scg_pkg::ST_CLKWAIT) |
                       (mode_q == `SCG_MODE_STANDBY) |
                       (mode_q == `SCG_MODE_EXTSTBY);
      end
    end
  end

  // ========================================================================
  // Converter: auto start on idle or noise entry, extended conversion after re-enable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      convStart_q    <= 1'b0;
      convExtended_q <= 1'b1;
      convEnPrev_q   <= 1'b0;
      convPowered_q  <= 1'b0;
    end else begin
      convStart_q   <= enter & convEnable & ~isDeep(sleepModeSelect);
      convEnPrev_q  <= convEnable;
      convPowered_q <= convEnable;
      if (convEnPrev_q & ~convEnable) begin
        convExtended_q <= 1'b1;
      end else if (convStart_q | convBegin) begin
        convExtended_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Analog helpers, watchdog, input buffers, timer0 integrity
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      compPowered_q     <= 1'b0;
      vrefEn_q          <= 1'b0;
      brownout_enable_fuse_q           <= 1'b0;
      wdtRun_q          <= 1'b0;
      inputBufEn_q      <= 1'b1;
      extIrqBufEn_q     <= 1'b1;
      timer0Undefined_q <= 1'b0;
    end else begin
      compPowered_q <= ~compDisableBit &
                       (~isDeep(mode_q) | (state_q == scg_pkg::ST_RUN));
      vrefEn_q      <= brownoutEnableFuse | convEnable |
                       (compBandgapSel & ~compDisableBit);
      brownout_enable_fuse_q       <= brownoutEnableFuse;
      wdtRun_q      <= wdtEnable;
      inputBufEn_q  <= (state_q != scg_pkg::ST_SLEEP) |
                       (mode_q == `SCG_MODE_IDLE) | (mode_q == `SCG_MODE_NOISE);
      extIrqBufEn_q <= 1'b1;
      if (enter) begin
        timer0Undefined_q <= isSaveLike(sleepModeSelect) & ~timer0AsyncClockBit;
      end
    end
  end

  // ========================================================================
  // Debug port: data out driven only while shifting
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      jtagActive_q <= 1'b0;
      tdoOut_q     <= 1'b0;
      tdoOe_q      <= 1'b0;
    end else begin
      jtagActive_q <= jtagOn;
      tdoOut_q     <= tdoData;
      tdoOe_q      <= jtagOn & tapShifting;
    end
  end

endmodule : scg_sleep_ctrl

/* File: rtl/scg_wake_match.sv */
// Combinational wake-up source filter for the mode being slept in.
// Assumes all source inputs are one-cycle or level requests in clk_sys.
`include "scg_regs.svh"
module scg_wake_match (
  input  wire logic            mode,
  input  wire scg_pkg::scg_mode_t sleepMode,
  input  wire logic            anyIrq,
  input  wire logic            compIrq,
  input  wire logic            compDisableBit,
  input  wire logic            convDoneIrq,
  input  wire logic            twiAddrMatch,
  input  wire logic            timer0Irq,
  input  wire logic            storeReadyIrq,
  input  wire logic [3:0]      upperExtLevelIrq,
  input  wire logic [3:0]      lowerExtIrq,
  input  wire logic            timer0AsyncClockBit,
  input  wire logic            t0AsyncWake,
  output logic                 wake
);

  logic deepSrc;

  // Sources that reach the core even with all generated clocks stopped
  assign deepSrc = twiAddrMatch | (|upperExtLevelIrq) | (|lowerExtIrq);

  // Select wake sources by sleep mode
  always_comb begin
    wake = 1'b0;
    unique case (sleepMode)
      `SCG_MODE_IDLE:    wake = anyIrq | (compIrq & ~compDisableBit);
      `SCG_MODE_NOISE:   wake = deepSrc | convDoneIrq | timer0Irq | storeReadyIrq;
      `SCG_MODE_PWRDOWN,
      `SCG_MODE_STANDBY: wake = deepSrc;
      `SCG_MODE_PWRSAVE,
      `SCG_MODE_EXTSTBY: wake = deepSrc | (timer0AsyncClockBit & t0AsyncWake);
      default:           wake = 1'b0;
    endcase
    wake = wake & mode;
  end

endmodule : scg_wake_match

/* File: shared/scg_pkg.sv */
// Types shared by the sleep-mode clock gating design files.
// Assumes nothing beyond a SystemVerilog compiler.
package scg_pkg;

  // ========================================================================
  // Controller states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_CLKWAIT,
    ST_HALT
  } scg_state_e;

  typedef logic [2:0] scg_mode_t;

endpackage : scg_pkg

/* File: shared/scg_regs.svh */
// Constants of the sleep-mode clock gating block: mode codes and counts.
// Assumes inclusion by every design file that decodes sleep modes.
//
// Functional notes
// - Mode 000 idle stops cpu and flash clocks
// - Idle wakes on any enabled interrupt
// - Idle or noise mode starts enabled conversion
// - Mode 001 noise reduction stops io, cpu, flash
// - Noise mode wakes on listed sources only
// - Mode 010 power-down stops oscillator and clocks
// - Power-down wakes on reset, address, external lines
// - Power-down wake waits fuse-selected start-up delay
// - Mode 011 power-save keeps async timer0 running
// - Power-save timer wake needs enables and global
// - Sync timer0 contents undefined after power-save
// - Mode 110 crystal standby, six-cycle wake
// - Mode 111 crystal extended standby, six-cycle wake
// - Converter stays enabled; re-enable means extended conversion
// - Comparator off in deep modes, reference kept
// - Comparator disable bit removes its wake source
// - Fused brown-out detector stays on while asleep
// - Enabled watchdog keeps running while asleep
// - Reference on only when detector, comparator, converter
// - Input buffers off when io and converter stopped
// - Debug fuse keeps main clock; disable bit kills jtag
// - Jtag enabled, not shifting: data out undriven
// - Core halted four cycles beyond start-up time
// - Reset during sleep restarts from reset vector
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH

// ==========================================================================
// Sleep mode select encodings
`define SCG_MODE_IDLE     3'h0
`define SCG_MODE_NOISE    3'h1
`define SCG_MODE_PWRDOWN  3'h2
`define SCG_MODE_PWRSAVE  3'h3
`define SCG_MODE_RSVD4    3'h4
`define SCG_MODE_RSVD5    3'h5
`define SCG_MODE_STANDBY  3'h6
`define SCG_MODE_EXTSTBY  3'h7

// ==========================================================================
// Timing counts in clock cycles
`define SCG_STANDBY_WAKE_CYC 16'h0006
`define SCG_HALT_EXTRA_CYC   16'h0004

// ==========================================================================
// Reset values
`define SCG_RST_MODE         3'h0
`define SCG_RST_CLK_EN       1'b1

`endif

/* File: tb/scg_core_model.sv */
// Partner model: the core issuing sleep and the interrupt sources.
// Assumes its tasks are called just after a rising edge of clk_sys.
module scg_core_model (
  input  wire logic       clk_sys,
  output logic            sleepEnableBit,
  output logic            sleepExec,
  output logic            anyIrq,
  output logic            twiAddrMatch,
  output logic            t0Ovf,
  output logic            t0Cmp,
  output logic            convDoneIrq,
  output logic            storeReadyIrq,
  output logic [3:0]      upperExtLevelIrq,
  output logic [3:0]      lowerExtIrq,
  output logic            resetReq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] src = 9'h000;
  logic [3:0] lineSel = 4'h1;
  // ======
  // Source lines; released lines fall back to inactive low
  assign {resetReq, t0Cmp, storeReadyIrq, convDoneIrq} = src[8:5];
  assign {t0Ovf, twiAddrMatch, anyIrq} = src[2:0];
  assign lowerExtIrq = src[4] ? lineSel : 4'h0;
  assign upperExtLevelIrq = src[3] ? lineSel : 4'h0;
  // Idle core at time zero
  initial begin
    sleepEnableBit = 1'b0;
    sleepExec = 1'b0;
  end
  // Sets the enable bit, then a one-cycle sleep instruction
  task automatic sleepReq(input logic en);
    sleepEnableBit = en;
    @(posedge clk_sys); #2;
    sleepExec = 1'b1;
    @(posedge clk_sys); #2;
    sleepExec = 1'b0;
    sleepEnableBit = 1'b0;
  endtask : sleepReq
  // Raises one source on a random line for n cycles
  task automatic wake(input int code, input int n);
    lineSel = 4'h1 << ($urandom % 4);
    src[code] = 1'b1;
    repeat (n) begin
      @(posedge clk_sys); #2;
    end
    src = 9'h000;
  endtask : wake
endmodule : scg_core_model

/* File: tb/scg_sleep_ctrl_checker.sv */
// Concurrent checks on the sleep controller ports, bound into it.
// Assumes the single clk_sys domain and the active-low rstn.
module scg_sleep_ctrl_checker (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       sleepEnableBit,
  input wire logic       sleepExec,
  input wire logic [2:0] sleepModeSelect,
  input wire logic       extCrystalSel,
  input wire logic       debugEnableFuse,
  input wire logic       jtagEnableFuse,
  input wire logic       jtagDisableBit,
  input wire logic       brownoutEnableFuse,
  input wire logic       wdtEnable,
  input wire logic       convEnable,
  input wire logic       anyIrq,
  input wire logic       resetReq,
  input wire logic       tapShifting,
  input wire logic       cpuClkEn_q,
  input wire logic       flashClkEn_q,
  input wire logic       ioClkEn_q,
  input wire logic       convClkEn_q,
  input wire logic       mainOscEn_q,
  input wire logic       sleeping_q,
  input wire logic       coreHalted_q,
  input wire logic       wakeDone_q,
  input wire logic       resetVector_q,
  input wire logic       convStart_q,
  input wire logic       brownout_enable_fuse_q,
  input wire logic       wdtRun_q,
  input wire logic       inputBufEn_q,
  input wire logic       jtagActive_q,
  input wire logic       tdoOe_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic               legal;
  logic               take;
  logic               hold;
  scg_pkg::scg_mode_t modeQ_q;
  // ======
  // Accepted request and the mode it chose
  assign legal = !sleepModeSelect[2] || (sleepModeSelect[1] && extCrystalSel);
  assign take = sleepExec && sleepEnableBit && legal && cpuClkEn_q && !sleeping_q
                && !coreHalted_q;
  assign hold = debugEnableFuse && jtagEnableFuse && !jtagDisableBit;
  // Remembers the mode of the last accepted request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      modeQ_q <= 3'h0;
    end else if (take) begin
      modeQ_q <= sleepModeSelect;
    end
  end
  // ======
  // Assertions
  enter_sleep_a: assert property (take |-> ##2 !cpuClkEn_q && sleeping_q)
    else $error("sleep not entered");
  refuse_sleep_a: assert property (sleepExec && !(sleepEnableBit && legal) && cpuClkEn_q
    && !sleeping_q && !coreHalted_q && !$past(take) |=> cpuClkEn_q [*2])
    else $error("refused sleep entered");
  idle_domains_a: assert property (sleeping_q && !cpuClkEn_q && modeQ_q == 3'h0
    |-> ioClkEn_q && convClkEn_q && !flashClkEn_q) else $error("idle domains");
  noise_domains_a: assert property (sleeping_q && !cpuClkEn_q && modeQ_q == 3'h1
    |-> !ioClkEn_q && convClkEn_q) else $error("noise domains");
  deep_domains_a: assert property (sleeping_q && $past(sleeping_q) && modeQ_q[1]
    |-> !ioClkEn_q && !convClkEn_q && !inputBufEn_q) else $error("deep mode domains on");
  osc_kept_a: assert property (sleeping_q && $past(sleeping_q) && modeQ_q[1]
    && (modeQ_q[2] || hold) |-> mainOscEn_q) else $error("oscillator stopped");
  conv_start_a: assert property (take && sleepModeSelect[2:1] == 2'b00 && convEnable
    |=> convStart_q) else $error("no conv start");
  keep_on_a: assert property (1'b1 |=> wdtRun_q == $past(wdtEnable)
    && brownout_enable_fuse_q == $past(brownoutEnableFuse)) else $error("wdt or bod off");
  halt_four_a: assert property ($rose(coreHalted_q) |-> coreHalted_q [*4])
    else $error("halt too short");
  idle_wake_a: assert property (sleeping_q && modeQ_q == 3'h0 && anyIrq
    |-> ##[4:10] wakeDone_q) else $error("no idle wake");
  reset_vec_a: assert property ($rose(resetReq) && sleeping_q
    |-> ##[1:2] resetVector_q) else $error("no reset vector");
  tdo_float_a: assert property (!tapShifting && !$past(tapShifting) |-> !tdoOe_q)
    else $error("tdo driven idle");
  jtag_off_a: assert property (jtagDisableBit || !jtagEnableFuse |=> !jtagActive_q)
    else $error("jtag still active");
endmodule : scg_sleep_ctrl_checker

bind scg_sleep_ctrl scg_sleep_ctrl_checker chk (.*);

/* File: tb/sleep_mode_clock_gating_tb.sv */
// Self-checking bench of the sleep controller with the core model.
// Assumes the checker is bound in and start-up counts are set to 8, 10, 12 and 14 cycles.
module sleep_mode_clock_gating_tb;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin errCount++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); end end
  localparam int T[4] = '{8, 10, 12, 14};
  localparam int MD[6] = '{0, 1, 2, 3, 6, 7};
  localparam int GD[6] = '{0, 5, 4, 2, 3, 7};
  localparam int BD[6] = '{-1, 0, 0, 2, 2, 0};
  localparam int RM[5] = '{4, 5, 6, 7, 0};
  localparam logic RX[5] = '{1, 1, 0, 0, 1};
  localparam logic RE[5] = '{1, 1, 1, 1, 0};
  logic clk_sys, rstn = 0, extCrystalSel = 1, debugEnableFuse = 0, jtagEnableFuse = 0;
  logic jtagDisableBit = 0, brownoutEnableFuse = 0, wdtEnable = 0, convEnable = 0;
  logic convBegin = 0, compDisableBit = 0, compBandgapSel = 0, timer0AsyncClockBit = 0;
  logic t0OvfIrqEn = 1, t0CmpIrqEn = 1, globalIrqEnable = 0, compIrq = 0;
  logic tapShifting = 0, tdoData = 0;
  logic [2:0] sleepModeSelect = 3'h0;
  logic [1:0] clockSelectFuses = 2'h0;
  logic sleepEnableBit, sleepExec, anyIrq, twiAddrMatch, t0Ovf, t0Cmp, convDoneIrq;
  logic storeReadyIrq, resetReq;
  logic [3:0] upperExtLevelIrq, lowerExtIrq;
  logic cpuClkEn_q, flashClkEn_q, ioClkEn_q, convClkEn_q, asyClkEn_q, mainOscEn_q;
  logic timerOscEn_q, sleeping_q, coreHalted_q, wakeDone_q, resetVector_q, convStart_q;
  logic convExtended_q, convPowered_q, compPowered_q, vrefEn_q, brownout_enable_fuse_q, wdtRun_q;
  logic inputBufEn_q, extIrqBufEn_q, timer0Undefined_q, jtagActive_q, tdoOut_q, tdoOe_q;
  logic [10:0] gates;
  logic [10:0] noteQ[$];
  logic        prev1 = 0, prev2 = 0;
  int          errCount = 0, numChecks = 0, cycN = 0, wakeCyc = 0, lastLat = 0;
  int          lat[8];
  scg_sleep_ctrl #(.TOUT0(16'h0008), .TOUT1(16'h000A), .TOUT2(16'h000C), .TOUT3(16'h000E))
    dut (.*);
  scg_core_model core (.*);
  assign gates = {cpuClkEn_q, flashClkEn_q, ioClkEn_q, convClkEn_q, asyClkEn_q, mainOscEn_q,
                  inputBufEn_q, compPowered_q, convPowered_q, vrefEn_q, timer0Undefined_q};
  // ======
  // Clock and helpers
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk_sys); #2;
      tapShifting = 1'($urandom);
      tdoData = 1'($urandom);
    end
  endtask : cyc
  // Expected gating word for a mode under the present settings
  function automatic logic [10:0] expG(input logic [2:0] m);
    logic lo;
    logic hold;
    lo = (m <= 3'h1);
    hold = !lo && debugEnableFuse && jtagEnableFuse && !jtagDisableBit;
    expG = {2'b00, m == 3'h0, lo, lo || (m[0] && timer0AsyncClockBit), lo || m[2] || hold,
            lo, lo && !compDisableBit, convEnable,
            brownoutEnableFuse || convEnable || (compBandgapSel && !compDisableBit),
            m[1] && m[0] && !timer0AsyncClockBit};
  endfunction : expG
  // Sleep in a mode, offer a non-waking then a waking source
  task automatic sleepWake(input logic [2:0] m, input int good, input int bad);
    int k;
    sleepModeSelect = m;
    globalIrqEnable = 1'b0;
    convEnable = (m <= 3'h1) | 1'($urandom);
    wdtEnable = 1'($urandom);
    brownoutEnableFuse = 1'($urandom);
    compDisableBit = 1'($urandom);
    compBandgapSel = 1'($urandom);
    timer0AsyncClockBit = (m[1] & m[0]) | 1'($urandom);
    cyc(1);
    noteQ.push_back(expG(m));
    core.sleepReq(1'b1);
    for (k = 0; k < 20 && sleeping_q !== 1'b1; k++) cyc(1);
    if (bad >= 0) begin
      core.wake(bad, 2);
      cyc(12);
      `CHK(sleeping_q, 1'b1)
    end
    globalIrqEnable = 1'b1;
    wakeCyc = cycN;
    core.wake(good, 2);
    for (k = 0; k < 200 && cpuClkEn_q !== 1'b1; k++) cyc(1);
    cyc(2);
  endtask : sleepWake
  task automatic results;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // ======
  // Monitor: takes the oldest note once sleep settles, times wake-ups
  always @(posedge clk_sys) begin
    cycN++;
    if (wakeDone_q === 1'b1) lastLat = cycN - wakeCyc;
    if (sleeping_q === 1'b1 && prev1 && !prev2) begin
      `CHK(gates, noteQ.pop_front())
    end
    prev2 = prev1;
    prev1 = (sleeping_q === 1'b1);
  end
  // Watchdog against a hang
  initial begin
    repeat (8000) @(posedge clk_sys);
    errCount++;
    results();
  end
  // ======
  // Main sequence
  initial begin
    int i;
    int k;
    void'($urandom(32'h90b3c67f));
    repeat (6) @(posedge clk_sys);
    #2;
    rstn = 1'b1;
    cyc(1);
    for (i = 0; i < 6; i++) begin
      sleepWake(3'(MD[i]), GD[i], BD[i]);
      lat[MD[i]] = lastLat;
    end
    `CHK(lat[2] - lat[6], T[0] - 6)
    `CHK(lat[3] - lat[7], T[0] - 6)
    `CHK(lat[1], lat[0])
    $display("test sleep modes done");
    for (i = 1; i < 4; i++) begin
      clockSelectFuses = 2'(i);
      sleepWake(3'h2, 4, 0);
      `CHK(lastLat - lat[2], T[i] - T[0])
    end
    $display("test start-up delays done");
    for (i = 0; i < 5; i++) begin
      sleepModeSelect = 3'(RM[i]);
      extCrystalSel = RX[i];
      core.sleepReq(RE[i]);
      cyc(3);
      `CHK(sleeping_q, 1'b0)
    end
    extCrystalSel = 1'b1;
    $display("test refused requests done");
    sleepModeSelect = 3'h2;
    noteQ.push_back(expG(3'h2));
    core.sleepReq(1'b1);
    cyc(4);
    core.wake(8, 1);
    for (k = 0; k < 3 && resetVector_q !== 1'b1; k++) cyc(1);
    `CHK(resetVector_q, 1'b1)
    for (k = 0; k < 20 && cpuClkEn_q !== 1'b1; k++) cyc(1);
    $display("test reset in sleep done");
    debugEnableFuse = 1'b1;
    jtagEnableFuse = 1'b1;
    sleepWake(3'h2, 4, -1);
    `CHK(jtagActive_q, 1'b1)
    jtagDisableBit = 1'b1;
    cyc(2);
    `CHK(jtagActive_q, 1'b0)
    `CHK(noteQ.size(), 0)
    $display("test debug hold done");
    results();
  end
endmodule : sleep_mode_clock_gating_tb
